// file: pkg/spi_eeprom_defs.svh
// Constants for the serial memory front end.
`ifndef SPI_EEPROM_DEFS_SVH
`define SPI_EEPROM_DEFS_SVH
`define EE_OP_READ        8'h03
`define EE_OP_WRITE       8'h02
`define EE_OP_LATCH_SET   8'h06
`define EE_DEPTH          16384
`define EE_ADDR_W         14
`define EE_PAGE_BYTES     64
`define EE_ADDR_MAX       14'h3FFF
`define EE_PROG_TIME_MS   5
`define EE_CLK_HZ         10000000
`define EE_PROG_CYCLES    ((`EE_PROG_TIME_MS * `EE_CLK_HZ) / 1000)
`define EE_FIFO_DEPTH     16
`endif

// file: pkg/spi_eeprom_pkg.sv
// Types shared by the serial memory front end.
package spi_eeprom_pkg;
  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR_HI, PH_ADDR_LO, PH_READ, PH_WRITE, PH_IGNORE
  } phase_t;
  typedef struct packed {
    logic [13:0] addr;
    logic [7:0]  data;
  } wr_word_t;
endpackage

// file: core/ee_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ee_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Handshake terms come straight from the fill count.
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage writes.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  // Pointers and count.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: core/spi_eeprom_serial_front_end.sv
// Serial memory front end: link sampling, decode, array and programming.
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_defs.svh"
module spi_eeprom_serial_front_end #(
  parameter int PROG_CYCLES = `EE_PROG_CYCLES,
  parameter int FIFO_DEPTH  = `EE_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Serial link pins.
  input  wire logic sel_n,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic pause_n,
  output logic      sdo,
  output logic      sdo_oe,
  // Status.
  output logic      prog_busy,
  output logic      latch_set
);
  // Array of byte locations.
  logic [7:0] array_mem [`EE_DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] sel_sync_ff;
  logic [1:0] clk_sync_ff;
  logic [1:0] sdi_sync_ff;
  logic [1:0] pause_sync_ff;
  logic       clk_prev_ff;
  logic       sel_prev_ff;

  // Two flops per pin before any logic looks at it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_sync_ff   <= 2'h3;
      clk_sync_ff   <= 2'h0;
      sdi_sync_ff   <= 2'h0;
      pause_sync_ff <= 2'h3;
      clk_prev_ff   <= 1'b0;
      sel_prev_ff   <= 1'b1;
    end
    else
    begin
      sel_sync_ff   <= {sel_sync_ff[0], sel_n};
      clk_sync_ff   <= {clk_sync_ff[0], sclk};
      sdi_sync_ff   <= {sdi_sync_ff[0], sdi};
      pause_sync_ff <= {pause_sync_ff[0], pause_n};
      clk_prev_ff   <= clk_sync_ff[1];
      sel_prev_ff   <= sel_sync_ff[1];
    end
  end

  logic sel_act;
  logic paused;
  logic rise;
  logic fall;
  logic sel_rise;
  logic sel_fall;
  assign sel_act  = !sel_sync_ff[1];
  assign paused   = !pause_sync_ff[1];
  // Clock edges are ignored while paused, so the bit count freezes.
  assign rise     = sel_act && !paused && clk_sync_ff[1] && !clk_prev_ff;
  assign fall     = sel_act && !paused && !clk_sync_ff[1] && clk_prev_ff;
  assign sel_rise = sel_sync_ff[1] && !sel_prev_ff;
  assign sel_fall = !sel_sync_ff[1] && sel_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Bit and byte assembly.
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  instr_ff;
  logic [7:0]  nxt_byte;
  logic        byte_done;
  spi_eeprom_pkg::phase_t phase_ff;
  logic [13:0] addr_ff;
  logic [5:0]  page_off_ff;
  logic [6:0]  wr_count_ff;
  logic        wr_armed_ff;
  logic        latch_pend_ff;
  logic        latch_ff;
  logic        busy_ff;
  logic        rd_loaded_ff;

  assign nxt_byte  = {shift_ff[6:0], sdi_sync_ff[1]};
  assign byte_done = rise && (bit_cnt_ff == 3'h7);

  // Bit counter restarts at select fall; first rise is bit seven.
  always_ff @(posedge clk)
  begin
    if (rst || sel_fall || !sel_act)
    begin
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 8'h00;
    end
    else if (rise)
    begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff   <= nxt_byte;
    end
  end

  // Instruction register holds the first byte of each transfer.
  always_ff @(posedge clk)
  begin
    if (rst)
      instr_ff <= 8'h00;
    else if (byte_done && phase_ff == spi_eeprom_pkg::PH_CMD)
      instr_ff <= nxt_byte;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path through the FIFO.
  spi_eeprom_pkg::wr_word_t fifo_in;
  spi_eeprom_pkg::wr_word_t fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_ff;

  // Data bytes wait in the FIFO until the program cycle drains them.
  assign fifo_in.addr  = {addr_ff[13:6], page_off_ff};
  assign fifo_in.data  = nxt_byte;
  assign fifo_in_valid = byte_done && phase_ff == spi_eeprom_pkg::PH_WRITE
                         && wr_count_ff < 7'h40;
  assign fifo_out_ready = busy_ff;

  ee_fifo #(
    .WIDTH ($bits(spi_eeprom_pkg::wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst || (sel_rise && !busy_ff && !wr_armed_ff)),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencing.
  always_ff @(posedge clk)
  begin
    if (rst || !sel_act)
      phase_ff <= spi_eeprom_pkg::PH_CMD;
    else if (byte_done)
    begin
      case (phase_ff)
        spi_eeprom_pkg::PH_CMD:
        begin
          if (busy_ff)
            phase_ff <= spi_eeprom_pkg::PH_IGNORE;
          else if (nxt_byte == `EE_OP_READ || nxt_byte == `EE_OP_WRITE)
            phase_ff <= spi_eeprom_pkg::PH_ADDR_HI;
          else
            phase_ff <= spi_eeprom_pkg::PH_IGNORE;
        end
        spi_eeprom_pkg::PH_ADDR_HI: phase_ff <= spi_eeprom_pkg::PH_ADDR_LO;
        spi_eeprom_pkg::PH_ADDR_LO:
          phase_ff <= (instr_ff == `EE_OP_READ) ? spi_eeprom_pkg::PH_READ
                                                : spi_eeprom_pkg::PH_WRITE;
        default: phase_ff <= phase_ff;
      endcase
    end
  end

  // Address pointer: upper two address bits are ignored.
  always_ff @(posedge clk)
  begin
    if (rst)
      addr_ff <= 14'h0000;
    else if (byte_done && phase_ff == spi_eeprom_pkg::PH_ADDR_HI)
      addr_ff <= {nxt_byte[5:0], addr_ff[7:0]};
    else if (byte_done && phase_ff == spi_eeprom_pkg::PH_ADDR_LO)
      addr_ff <= {addr_ff[13:8], nxt_byte};
    else if (fall && phase_ff == spi_eeprom_pkg::PH_READ
             && bit_cnt_ff == 3'h0 && rd_loaded_ff)
      addr_ff <= (addr_ff == `EE_ADDR_MAX) ? 14'h0000 : addr_ff + 14'h1;
  end

  // Page offset counter wraps inside the page.
  always_ff @(posedge clk)
  begin
    if (rst || !sel_act)
    begin
      page_off_ff <= 6'h00;
      wr_count_ff <= 7'h00;
    end
    else if (byte_done && phase_ff == spi_eeprom_pkg::PH_ADDR_LO)
      page_off_ff <= nxt_byte[5:0];
    else if (fifo_in_valid && fifo_in_ready)
    begin
      page_off_ff <= page_off_ff + 6'h01;
      wr_count_ff <= wr_count_ff + 7'h01;
    end
  end

  // A write is armed only if a whole number of data bytes arrived.
  always_ff @(posedge clk)
  begin
    if (rst || sel_fall)
      wr_armed_ff <= 1'b0;
    else if (phase_ff == spi_eeprom_pkg::PH_WRITE)
      wr_armed_ff <= latch_ff && wr_count_ff != 7'h00 && bit_cnt_ff == 3'h0;
  end

  // Latch set is pending after bit eight, applied on select rise.
  always_ff @(posedge clk)
  begin
    if (rst || sel_fall)
      latch_pend_ff <= 1'b0;
    else if (byte_done)
      latch_pend_ff <= (phase_ff == spi_eeprom_pkg::PH_CMD)
                       && (nxt_byte == `EE_OP_LATCH_SET);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      latch_ff <= 1'b0;
    else if (sel_rise && latch_pend_ff && !busy_ff && bit_cnt_ff == 3'h0)
      latch_ff <= 1'b1;
    else if (busy_ff && prog_cnt_ff == '0)
      latch_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-timed programming cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_ff     <= 1'b0;
      prog_cnt_ff <= '0;
    end
    else if (!busy_ff && sel_rise && wr_armed_ff)
    begin
      busy_ff     <= 1'b1;
      prog_cnt_ff <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES - 1);
    end
    else if (busy_ff)
    begin
      if (prog_cnt_ff == '0)
        busy_ff <= 1'b0;
      else
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
    end
  end

  // Counts busy cycles so the length bound is checked without a long delay.
  logic [31:0] busy_len_ff;
  always_ff @(posedge clk)
  begin
    if (rst || !busy_ff)
      busy_len_ff <= 32'h0000_0000;
    else
      busy_len_ff <= busy_len_ff + 32'h0000_0001;
  end

  // Array write as FIFO drains during the busy window.
  always_ff @(posedge clk)
  begin
    if (fifo_out_valid && fifo_out_ready)
      array_mem[fifo_out.addr] <= fifo_out.data;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data output, shifted after falling clock edges.
  logic [7:0] out_sr_ff;
  always_ff @(posedge clk)
  begin
    if (rst || !sel_act)
    begin
      out_sr_ff    <= 8'h00;
      rd_loaded_ff <= 1'b0;
    end
    else if (fall && phase_ff == spi_eeprom_pkg::PH_READ
             && bit_cnt_ff == 3'h0)
    begin
      out_sr_ff    <= array_mem[rd_loaded_ff ? addr_ff + 14'h1 : addr_ff];
      rd_loaded_ff <= 1'b1;
    end
    else if (fall && phase_ff == spi_eeprom_pkg::PH_READ)
      out_sr_ff <= {out_sr_ff[6:0], 1'b0};
  end

  // Output enable only while selected, not paused, and reading.
  assign sdo       = out_sr_ff[7];
  assign sdo_oe    = sel_act && !paused && rd_loaded_ff;
  assign prog_busy = busy_ff;
  assign latch_set = latch_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_prog_bounded: assert property (@(posedge clk) disable iff (rst)
    busy_ff |-> busy_len_ff < PROG_CYCLES)
    else $error("Program cycle too long.");
  a_instr_capture: assert property (@(posedge clk) disable iff (rst)
    byte_done && phase_ff == spi_eeprom_pkg::PH_CMD
    |=> instr_ff == $past(nxt_byte))
    else $error("Instruction register not loaded.");
  a_first_bit: assert property (@(posedge clk) disable iff (rst)
    sel_fall |=> bit_cnt_ff == 3'h0)
    else $error("Bit count not cleared on select.");
  a_pause_freeze: assert property (@(posedge clk) disable iff (rst)
    paused && sel_act |=> $stable(bit_cnt_ff))
    else $error("Bit count moved during pause.");
  a_addr_wrap: assert property (@(posedge clk) disable iff (rst)
    addr_ff == 14'h3FFF && fall && rd_loaded_ff && bit_cnt_ff == 3'h0
    && phase_ff == spi_eeprom_pkg::PH_READ |=> addr_ff == 14'h0000)
    else $error("Pointer did not wrap.");
  a_latch_rise: assert property (@(posedge clk) disable iff (rst)
    $rose(latch_ff) |-> $past(sel_rise))
    else $error("Latch set without select rise.");
  a_page_limit: assert property (@(posedge clk) disable iff (rst)
    wr_count_ff <= 7'h40)
    else $error("Too many page bytes.");
  a_page_wrap: assert property (@(posedge clk) disable iff (rst)
    fifo_in_valid && fifo_in_ready && page_off_ff == 6'h3F
    && phase_ff == spi_eeprom_pkg::PH_WRITE |=> page_off_ff == 6'h00)
    else $error("Page offset did not wrap.");
  a_out_tristate: assert property (@(posedge clk) disable iff (rst)
    !sel_act || paused |-> !sdo_oe)
    else $error("Output driven when idle.");
endmodule
`default_nettype wire

// file: bench/spi_host_model.sv
// Host controller model that drives the serial link of the memory.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock and data coming back from the memory.
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  // Link pins driven towards the memory.
  output logic      sel_n,
  output logic      sclk,
  output logic      sdi,
  output logic      pause_n
);
  logic paused_oe;

  // Idle link: deselected, clock parked low, no pause.
  initial
  begin
    sel_n     = 1'b1;
    sclk      = 1'b0;
    sdi       = 1'b0;
    pause_n   = 1'b1;
    paused_oe = 1'b0;
  end

  // Waits system clocks; four of them make half a link period.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Opens a frame and leaves time for the select to be seen.
  task automatic open_frame();
    tick(4);
    sel_n <= 1'b0;
    tick(4);
  endtask

  // Closes a frame after a whole byte; the data line no longer holds.
  task automatic close_frame();
    tick(4);
    sel_n <= 1'b1;
    sdi   <= ~sdi;
    tick(8);
  endtask

  // Moves a byte each way, top bit first; may pause after four bits.
  task automatic xfer(input logic [7:0] tx, input logic hold,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi  <= tx[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      // An undriven output line reads as the inverse of its last level.
      rx[i] = sdo_oe ? sdo : ~sdo;
      sclk <= 1'b0;
      if (hold && i == 4)
      begin
        tick(4);
        pause_n <= 1'b0;
        tick(4);
        paused_oe = sdo_oe;
        sclk <= 1'b1;
        sdi  <= ~sdi;
        tick(4);
        sclk <= 1'b0;
        tick(4);
        pause_n <= 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_spi_eeprom_serial_front_end.sv
// Self-checking bench for the serial memory front end.
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_defs.svh"
module tb_spi_eeprom_serial_front_end;
  localparam int PROG = 200;
  logic        clk, rst, sel_n, sclk, sdi, pause_n;
  logic        sdo, sdo_oe, prog_busy, latch_set;
  logic [15:0] rnd;
  logic [7:0]  d [4];
  logic [7:0]  rb [4];
  logic [7:0]  rx;
  int          mismatches, n_compared;

  // System clock at 10 MHz.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  spi_eeprom_serial_front_end #(.PROG_CYCLES(PROG)) u_dut (
    .clk(clk), .rst(rst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .prog_busy(prog_busy), .latch_set(latch_set));

  spi_host_model u_host (
    .clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sel_n(sel_n),
    .sclk(sclk), .sdi(sdi), .pause_n(pause_n));

  // Next value of the random source.
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Compares and reports a difference at once.
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Waits out the program cycle under bounds and measures it.
  task automatic wait_prog();
    int k;
    int cnt;
    k = 0;
    cnt = 0;
    while (prog_busy !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    while (prog_busy === 1'b1 && cnt < PROG + 50)
    begin
      @(negedge clk);
      cnt++;
    end
    check("prog_start", k < 20, 1);
    check("prog_time", cnt > PROG / 2 && cnt <= PROG, 1);
    check("latch_after", latch_set, 0);
    if (k >= 20 || cnt >= PROG + 50)
      end_of_test();
  endtask

  // Sets the latch, then writes n bytes from d[s] at address a.
  task automatic do_write(input logic [15:0] a, input int s, n,
                          input logic hold);
    u_host.open_frame();
    u_host.xfer(`EE_OP_LATCH_SET, 1'b0, rx);
    u_host.close_frame();
    check("latch_set", latch_set, 1);
    u_host.open_frame();
    u_host.xfer(`EE_OP_WRITE, 1'b0, rx);
    u_host.xfer(a[15:8], 1'b0, rx);
    u_host.xfer(a[7:0], 1'b0, rx);
    for (int i = 0; i < n; i++)
      u_host.xfer(d[s + i], hold && i == 0, rx);
    u_host.close_frame();
    wait_prog();
  endtask

  // Reads n bytes from address a into rb.
  task automatic do_read(input logic [15:0] a, input int n,
                         input logic hold);
    u_host.open_frame();
    u_host.xfer(`EE_OP_READ, 1'b0, rx);
    u_host.xfer(a[15:8], 1'b0, rx);
    u_host.xfer(a[7:0], 1'b0, rx);
    for (int i = 0; i < n; i++)
      u_host.xfer(rnd[7:0], hold && i == 0, rb[i]);
    check("oe_reading", sdo_oe, 1);
    u_host.close_frame();
    check("oe_deselected", sdo_oe, 0);
    if (hold)
      check("oe_paused", u_host.paused_oe, 0);
  endtask

  // Main sequence: reset, refused write, page and array wrap, random.
  initial
  begin
    rst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    rnd = 16'hC70B;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    check("oe_reset", sdo_oe, 0);
    check("busy_reset", prog_busy, 0);
    check("latch_reset", latch_set, 0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      d[i] = rnd[7:0];
    end
    u_host.open_frame();
    u_host.xfer(`EE_OP_LATCH_SET, 1'b0, rx);
    u_host.xfer(`EE_OP_WRITE, 1'b0, rx);
    u_host.xfer(8'h00, 1'b0, rx);
    u_host.xfer(8'h10, 1'b0, rx);
    u_host.xfer(d[3], 1'b0, rx);
    u_host.close_frame();
    repeat (20) @(negedge clk);
    check("no_prog", prog_busy, 0);
    check("no_latch", latch_set, 0);
    do_write(16'hFFFF, 0, 2, 1'b1);
    do_write(16'h0000, 2, 1, 1'b0);
    do_read(16'h3FFF, 2, 1'b1);
    check("rd_3FFF", rb[0], d[0]);
    check("rd_wrap", rb[1], d[2]);
    do_read(16'hBFC0, 1, 1'b0);
    check("rd_page", rb[0], d[1]);
    rnd = lfsr(rnd);
    do_write({2'b00, rnd[13:0]}, 3, 1, 1'b0);
    do_read({2'b00, rnd[13:0]}, 1, 1'b0);
    check("rd_random", rb[0], d[3]);
    end_of_test();
  end
endmodule
`default_nettype wire
